// *** bench/framer_model.sv ***
// Behavioural framer and codec side of the serial audio port control block.
// Assumes the bench asks for each load or store with a one-cycle command on pclk.
`timescale 1ns/1ps
module framer_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load_cmd,
	input wire logic store_cmd,
	input wire logic [31:0] store_data,
	output logic tx_load,
	output logic rx_store,
	output logic [31:0] rx_word,
	output logic ext_clk
);
	logic [1:0] div_r; // Divide-by-three phase counter
	// Transfer pulses follow the command by one edge, as a slot would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_load <= 1'b0;
			rx_store <= 1'b0;
			rx_word <= 32'h0;
		end else begin
			tx_load <= load_cmd;
			rx_store <= store_cmd;
			// Word bus flips outside a store, so a late sample is caught
			rx_word <= store_cmd ? store_data : ~rx_word;
		end
	end
	// Free-running master clock, six pclk periods; it has no frame gating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 2'h0;
			ext_clk <= 1'b0;
		end else if (div_r == 2'h2) begin
			div_r <= 2'h0;
			ext_clk <= !ext_clk;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
endmodule // framer_model

// *** bench/tb_top.sv ***
// Self-checking bench for the serial audio port control block.
// Assumes the map header gives bus addresses and the framer model drives the link side.
`timescale 1ns/1ps
`include "serial_audio_port_map.svh"
`define CHK(g, e) check_val(33'(g), 33'(e))
module tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rx_word, store_data = 32'h0;
	logic pready, pslverr, ext_clk, serial_clock, tx_load, rx_store, port_irq, tx_dma_req, rx_dma_req;
	logic [15:0] tx_left_half, tx_right_half;
	logic tx_left_send, tx_right_send, load_cmd = 1'b0, store_cmd = 1'b0, frame_sync_err = 1'b0;
	logic tx_ctrl_ready = 1'b0, rx_ctrl_ready = 1'b0;
	logic [3:0] tx_left_slot_num, tx_right_slot_num;
	logic [32:0] exp_q[$], msk_q[$]; // Read notes, oldest first
	logic [31:0] txq[$], rxq[$]; // Words held in the FIFOs
	int fails = 0, total_checks = 0, cycles = 0;
	localparam logic [32:0] all_bits = 33'h1_ffff_ffff;
	localparam logic [11:0] regs [4] = '{`SAP_ADDR_IER, `SAP_ADDR_FCR, `SAP_ADDR_CSR, `SAP_ADDR_TSA};
	// Legal field codes only; reserved bits get ones on purpose
	localparam logic [31:0] wv [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_fffc, 32'hffff_fefd};
	localparam logic [15:0] keep [4] = '{16'hff3f, 16'hf0e0, 16'hdf04, 16'h8ecd};
	localparam logic [2:0] wcode [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
	localparam int tthr [5] = '{16, 12, 8, 4, 1};
	localparam int rthr [5] = '{1, 4, 8, 12, 16};

	serial_audio_port_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_master_clock_pin(ext_clk), .serial_clock(serial_clock), .tx_load(tx_load),
		.tx_left_half(tx_left_half), .tx_right_half(tx_right_half), .tx_left_send(tx_left_send),
		.tx_right_send(tx_right_send), .tx_left_slot_num(tx_left_slot_num),
		.tx_right_slot_num(tx_right_slot_num), .rx_store(rx_store), .rx_word(rx_word),
		.frame_sync_err(frame_sync_err), .tx_ctrl_ready(tx_ctrl_ready), .rx_ctrl_ready(rx_ctrl_ready),
		.port_irq(port_irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
	framer_model u_far (.pclk(pclk), .presetn(presetn), .load_cmd(load_cmd), .store_cmd(store_cmd),
		.store_data(store_data), .tx_load(tx_load), .rx_store(rx_store), .rx_word(rx_word), .ext_clk(ext_clk));

	// 40 ns clock
	always #20 pclk = !pclk;

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check_val(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer plus an idle cycle, so flags settle before the next one
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic store(input logic [31:0] w);
		store_cmd <= 1'b1;
		store_data <= w;
		@(posedge pclk);
		store_cmd <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	// Channel halves one edge after the framer load
	task automatic load(input logic [31:0] e);
		load_cmd <= 1'b1;
		@(posedge pclk);
		load_cmd <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK({tx_left_half, tx_right_half}, e);
	endtask

	task automatic irq_chk(input logic [15:0] ier, input logic i, input logic t, input logic r);
		wr(`SAP_ADDR_IER, {16'h0, ier});
		repeat (3) @(posedge pclk);
		`CHK({port_irq, tx_dma_req, rx_dma_req}, {i, t, r});
	endtask

	// Skip two periods after the change, then time one high and one low phase
	task automatic clk_chk(input logic [15:0] cs, input int eh, input int el);
		int hi, lo;
		hi = 0;
		lo = 0;
		wr(`SAP_ADDR_CSR, {16'h0, cs});
		repeat (2) begin
			while (serial_clock !== 1'b0) @(posedge pclk);
			while (serial_clock !== 1'b1) @(posedge pclk);
		end
		while (serial_clock === 1'b1) begin
			hi++;
			@(posedge pclk);
		end
		while (serial_clock === 1'b0) begin
			lo++;
			@(posedge pclk);
		end
		`CHK({hi[15:0], lo[15:0]}, {eh[15:0], el[15:0]});
	endtask

	// Read monitor: oldest note against each completed read
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
			`CHK({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
	end

	// Hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			results;
		end
	end

	initial begin
		logic [31:0] w;
		logic [3:0] ls, rs;
		int p, d;
		void'($urandom(32'h0d1e7a60));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SAP_ADDR_IER, 0, all_bits);
		rd(`SAP_ADDR_FCR, 16'h1000, all_bits);
		rd(`SAP_ADDR_CSR, 16'hc000, all_bits);
		rd(`SAP_ADDR_TSA, 0, all_bits);
		rd(12'h0fc, 33'h1_0000_0000, all_bits);
		for (int i = 0; i < 4; i++) begin
			wr(regs[i], wv[i]);
			rd(regs[i], keep[i], all_bits);
		end
		wr(`SAP_ADDR_IER, 0);
		wr(`SAP_ADDR_TSA, 0);
		wr(`SAP_ADDR_STAT, 32'h3f);
		// Every legal watermark code (000 and 100 to 111) at every fill level
		for (int f = 0; f <= 16; f++) begin
			for (int k = 0; k < 5; k++) begin
				wr(`SAP_ADDR_FCR, {16'h0, wcode[k], 5'h0, wcode[k], 5'h0});
				rd(`SAP_ADDR_FCR, {wcode[k], 5'(16 - f), wcode[k], 5'(f)}, all_bits);
				rd(`SAP_ADDR_STAT, {f == 0, 16 - f >= tthr[k], 2'b0, f == 16, f >= rthr[k], 8'h0}, 33'h3300);
			end
			if (f < 16) begin
				w = $urandom;
				txq.push_back(w);
				wr(`SAP_ADDR_TXD, w);
				w = $urandom;
				rxq.push_back(w);
				store(w);
			end
		end
		// Overflow both ways and a frame sync error
		wr(`SAP_ADDR_TXD, 32'h1234_5678);
		store(32'h0bad_0bad);
		frame_sync_err <= 1'b1;
		@(posedge pclk);
		frame_sync_err <= 1'b0;
		wr(`SAP_ADDR_STAT, 0);
		rd(`SAP_ADDR_STAT, 33'h19, 33'h1f);
		irq_chk(16'h0011, 1'b1, 1'b0, 1'b0);
		wr(`SAP_ADDR_STAT, 32'h01);
		irq_chk(16'h0011, 1'b1, 1'b0, 1'b0);
		wr(`SAP_ADDR_STAT, 32'h10);
		irq_chk(16'h0011, 1'b0, 1'b0, 1'b0);
		irq_chk(16'h0008, 1'b1, 1'b0, 1'b0);
		irq_chk(16'h0100, 1'b1, 1'b0, 1'b0);
		irq_chk(16'h0900, 1'b0, 1'b0, 1'b1);
		tx_ctrl_ready <= 1'b1;
		rx_ctrl_ready <= 1'b1;
		irq_chk(16'h4000, 1'b1, 1'b0, 1'b0);
		rd(`SAP_ADDR_STAT, 33'h4400, 33'h4400);
		tx_ctrl_ready <= 1'b0;
		rx_ctrl_ready <= 1'b0;
		wr(`SAP_ADDR_STAT, 32'h3f);
		// Drain both FIFOs, then one more each way
		for (int i = 0; i < 16; i++) begin
			w = txq.pop_front();
			load(w);
			rd(`SAP_ADDR_RXD, rxq.pop_front(), all_bits);
		end
		load(w);
		rd(`SAP_ADDR_RXD, 0, 33'h1_0000_0000);
		rd(`SAP_ADDR_STAT, 33'h2006, 33'h230f);
		wr(`SAP_ADDR_STAT, 32'h3f);
		irq_chk(16'h9000, 1'b0, 1'b1, 1'b0);
		irq_chk(16'h1000, 1'b1, 1'b0, 1'b0);
		irq_chk(16'h8000, 1'b0, 1'b1, 1'b0);
		w = $urandom;
		wr(`SAP_ADDR_TXD, w);
		repeat (3) @(posedge pclk);
		`CHK(tx_dma_req, 1);
		// Slots, channel enables and left repeat
		ls = 4'($urandom_range(14, 0));
		rs = 4'((ls + 1 + $urandom_range(13, 0)) % 15);
		wr(`SAP_ADDR_TSA, {16'h0, 1'b1, 3'b0, ls, 2'b11, 2'b0, rs});
		repeat (3) @(posedge pclk);
		`CHK({tx_left_send, tx_right_send, tx_left_slot_num, tx_right_slot_num}, {2'b11, ls, rs});
		load({w[31:16], w[31:16]});
		wr(`SAP_ADDR_TSA, {16'h0, 1'b1, 3'b0, ls, 4'h0, rs});
		repeat (3) @(posedge pclk);
		`CHK({tx_left_send, tx_right_send}, 2'b10);
		wr(`SAP_ADDR_TSA, {16'h0, 1'b1, 3'b0, ls, 4'h8, ls});
		repeat (3) @(posedge pclk);
		`CHK({tx_left_send, tx_right_send}, 2'b00);
		rd(`SAP_ADDR_STAT, 33'h20, 33'h20);
		// Reset in mid-run: registers, levels and flags return to their reset values
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SAP_ADDR_TSA, 0, all_bits);
		rd(`SAP_ADDR_FCR, 16'h1000, all_bits);
		rd(`SAP_ADDR_STAT, 33'h3000, 33'h3f3f);
		// Baud generator: output codes 0 to 4 with a random prescaler
		for (int c = 0; c < 5; c++) begin
			p = $urandom_range(31, 0);
			d = (p + 1) << (c + 1);
			clk_chk({3'b100, 5'(p), 5'h0, 3'(c)}, d / 2, d - d / 2);
		end
		clk_chk(16'h9f04, 512, 512);
		clk_chk(16'h8007, 1, 1);
		clk_chk(16'h8107, 1, 1);
		clk_chk(16'h8000, 1, 1);
		clk_chk(16'hc000, 1, 1);
		clk_chk(16'h4000, 3, 3);
		clk_chk(16'h0000, 6, 6);
		results;
	end
endmodule // tb_top

// *** hdl/serial_audio_port_control.sv ***
// Register control of a framed serial audio port: APB slave, events, DMA routing, FIFOs, baud divider.
// Assumes the framer drives tx_load, rx_store and frame_sync_err synchronous to pclk.
`timescale 1ns/1ps
`include "serial_audio_port_map.svh"
module serial_audio_port_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_master_clock_pin,
	output logic serial_clock,
	input wire logic tx_load,
	output logic [15:0] tx_left_half,
	output logic [15:0] tx_right_half,
	output logic tx_left_send,
	output logic tx_right_send,
	output logic [3:0] tx_left_slot_num,
	output logic [3:0] tx_right_slot_num,
	input wire logic rx_store,
	input wire logic [31:0] rx_word,
	input wire logic frame_sync_err,
	input wire logic tx_ctrl_ready,
	input wire logic rx_ctrl_ready,
	output logic port_irq,
	output logic tx_dma_req,
	output logic rx_dma_req
);

	// Address decode, used by read mux and write strobes
	function automatic serial_audio_port_pkg::reg_idx_t reg_index(input logic [11:0] a);
		case (a)
			`SAP_ADDR_IER: reg_index = serial_audio_port_pkg::IDX_IER;
			`SAP_ADDR_FCR: reg_index = serial_audio_port_pkg::IDX_FCR;
			`SAP_ADDR_CSR: reg_index = serial_audio_port_pkg::IDX_CSR;
			`SAP_ADDR_TSA: reg_index = serial_audio_port_pkg::IDX_TSA;
			`SAP_ADDR_STAT: reg_index = serial_audio_port_pkg::IDX_STAT;
			`SAP_ADDR_TXD: reg_index = serial_audio_port_pkg::IDX_TXD;
			`SAP_ADDR_RXD: reg_index = serial_audio_port_pkg::IDX_RXD;
			default: reg_index = serial_audio_port_pkg::IDX_NONE;
		endcase
	endfunction

	// Empty stages needed for a transmit request; prohibited codes act as 000
	function automatic serial_audio_port_pkg::level_t tx_level(input logic [2:0] c);
		case (c)
			3'h4: tx_level = `SAP_LVL_12;
			3'h5: tx_level = `SAP_LVL_8;
			3'h6: tx_level = `SAP_LVL_4;
			3'h7: tx_level = `SAP_LVL_1;
			default: tx_level = `SAP_DEPTH;
		endcase
	endfunction

	// Valid stages needed for a receive request; prohibited codes act as 000
	function automatic serial_audio_port_pkg::level_t rx_level(input logic [2:0] c);
		case (c)
			3'h4: rx_level = `SAP_LVL_4;
			3'h5: rx_level = `SAP_LVL_8;
			3'h6: rx_level = `SAP_LVL_12;
			3'h7: rx_level = `SAP_DEPTH;
			default: rx_level = `SAP_LVL_1;
		endcase
	endfunction

	// Prescaler ratio times output ratio; prohibited divider codes act as 000
	function automatic serial_audio_port_pkg::div_t div_total(input logic [4:0] ps, input logic [2:0] dv);
		serial_audio_port_pkg::div_t base;
		base = serial_audio_port_pkg::div_t'({6'h00, ps}) + `SAP_DIV_ONE;
		case (dv)
			3'h1: div_total = base << 2;
			3'h2: div_total = base << 3;
			3'h3: div_total = base << 4;
			3'h4: div_total = base << 5;
			3'h7: div_total = base;
			default: div_total = base << 1;
		endcase
	endfunction

	serial_audio_port_pkg::reg16_t ier_r; // Enables and DMA selects
	serial_audio_port_pkg::reg16_t csr_r; // Clock select
	serial_audio_port_pkg::reg16_t tsa_r; // Transmit slot assign
	logic [2:0] txwm_r; // Transmit watermark code
	logic [2:0] rxwm_r; // Receive watermark code
	logic [31:0] tx_mem [16]; // Transmit stages
	logic [31:0] rx_mem [16]; // Receive stages
	serial_audio_port_pkg::ptr_t tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	serial_audio_port_pkg::level_t tx_cnt_r, rx_cnt_r; // Words held
	logic tdreq_r, rdreq_r; // Transfer request flags
	logic tdreq_nxt, rdreq_nxt;
	logic [`SAP_ERR_W-1:0] err_r; // Sticky error flags
	logic [`SAP_ERR_W-1:0] err_set, err_clr;
	logic [31:0] rd_nxt; // Read data for the current setup
	serial_audio_port_pkg::reg16_t stat; // Live status view
	serial_audio_port_pkg::reg16_t route; // Request bits sent to DMA instead of CPU
	serial_audio_port_pkg::reg_idx_t idx;
	logic setup, done, wr, rd;
	logic tx_full, tx_empty, rx_full, rx_empty;
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic tx_push_req, rx_pop_req;
	logic sa_err;
	serial_audio_port_pkg::div_t div_sel; // Total division in use
	serial_audio_port_pkg::div_t bcnt_r; // Baud counter
	logic ext_d_r; // Previous pin level for edge detect
	logic mtick; // One master clock event
	logic direct; // Serial clock taken from the pin level itself, or toggled on each pclk

	// Bus phases: setup captures data, access completes one cycle later
	assign setup = psel & ~penable;
	assign done = psel & penable & pready;
	assign idx = reg_index(paddr);
	assign wr = done & pwrite;
	assign rd = done & ~pwrite;

	// FIFO levels and accepted moves
	assign tx_full = (tx_cnt_r == `SAP_DEPTH);
	assign tx_empty = (tx_cnt_r == 5'h00);
	assign rx_full = (rx_cnt_r == `SAP_DEPTH);
	assign rx_empty = (rx_cnt_r == 5'h00);
	assign tx_push_req = wr & (idx == serial_audio_port_pkg::IDX_TXD);
	assign rx_pop_req = rd & (idx == serial_audio_port_pkg::IDX_RXD);
	assign tx_push = tx_push_req & ~tx_full;
	assign tx_pop = tx_load & ~tx_empty;
	assign rx_push = rx_store & ~rx_full;
	assign rx_pop = rx_pop_req & ~rx_empty;

	// Overlapping left and right slots is a slot assign error
	assign sa_err = tsa_r[`SAP_B_LENA] & tsa_r[`SAP_B_RENA] & (tsa_r[`SAP_F_LSLT] == tsa_r[`SAP_F_RSLT]);

	// Error causes and write-one clears
	always_comb begin
		err_set = '0;
		err_set[`SAP_B_SAERR] = sa_err;
		err_set[`SAP_B_FSERR] = frame_sync_err;
		err_set[`SAP_B_TFOVF] = tx_push_req & tx_full;
		err_set[`SAP_B_TFUDF] = tx_load & tx_empty;
		err_set[`SAP_B_RFUDF] = rx_pop_req & rx_empty;
		err_set[`SAP_B_RFOVF] = rx_store & rx_full;
		err_clr = '0;
		if (wr && idx == serial_audio_port_pkg::IDX_STAT) begin
			err_clr = pwdata[`SAP_F_ERR];
		end
	end

	// Sticky errors; a new event wins over a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < `SAP_ERR_W; gi++) begin : g_err
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					err_r[gi] <= 1'b0;
				end else begin
					err_r[gi] <= err_set[gi] | (err_r[gi] & ~err_clr[gi]);
				end
			end
		end
	endgenerate

	// Status view; reserved bits stay zero
	always_comb begin
		stat = '0;
		stat[`SAP_B_TXRDY] = tx_ctrl_ready;
		stat[`SAP_B_TXEMP] = tx_empty;
		stat[`SAP_B_TDREQ] = tdreq_r;
		stat[`SAP_B_RXRDY] = rx_ctrl_ready;
		stat[`SAP_B_RXFUL] = rx_full;
		stat[`SAP_B_RDREQ] = rdreq_r;
		stat[`SAP_F_ERR] = err_r;
		route = '0;
		route[`SAP_B_TDREQ] = ier_r[`SAP_B_TXDMA];
		route[`SAP_B_RDREQ] = ier_r[`SAP_B_RXDMA];
	end

	// Request flags follow the watermark; one DMA data access drops them for a cycle
	always_comb begin
		tdreq_nxt = ((`SAP_DEPTH - tx_cnt_r) >= tx_level(txwm_r)) & ~(tx_push_req & ier_r[`SAP_B_TXDMA]);
		rdreq_nxt = (rx_cnt_r >= rx_level(rxwm_r)) & ~(rx_pop_req & ier_r[`SAP_B_RXDMA]);
	end

	// Request flags and routed outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdreq_r <= 1'b0;
			rdreq_r <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
			port_irq <= 1'b0;
		end else begin
			tdreq_r <= tdreq_nxt;
			rdreq_r <= rdreq_nxt;
			tx_dma_req <= tdreq_nxt & ier_r[`SAP_B_TXDMA];
			rx_dma_req <= rdreq_nxt & ier_r[`SAP_B_RXDMA];
			port_irq <= |(ier_r & `SAP_IER_EVT & stat & ~route);
		end
	end

	// Control registers; only documented bits are stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_r <= '0;
			csr_r <= `SAP_CSR_RST;
			tsa_r <= '0;
			txwm_r <= '0;
			rxwm_r <= '0;
		end else if (wr) begin
			case (idx)
				serial_audio_port_pkg::IDX_IER: ier_r <= pwdata[15:0] & `SAP_IER_WMASK;
				serial_audio_port_pkg::IDX_CSR: csr_r <= pwdata[15:0] & `SAP_CSR_WMASK;
				serial_audio_port_pkg::IDX_TSA: tsa_r <= pwdata[15:0] & `SAP_TSA_WMASK;
				serial_audio_port_pkg::IDX_FCR: begin
					txwm_r <= pwdata[`SAP_F_TXWM];
					rxwm_r <= pwdata[`SAP_F_RXWM];
				end
				default: ;
			endcase
		end
	end

	// Read mux; usable areas are computed from the live levels
	always_comb begin
		rd_nxt = '0;
		case (idx)
			serial_audio_port_pkg::IDX_IER: rd_nxt[15:0] = ier_r;
			serial_audio_port_pkg::IDX_FCR: rd_nxt[15:0] = {txwm_r, `SAP_DEPTH - tx_cnt_r, rxwm_r, rx_cnt_r};
			serial_audio_port_pkg::IDX_CSR: rd_nxt[15:0] = csr_r;
			serial_audio_port_pkg::IDX_TSA: rd_nxt[15:0] = tsa_r;
			serial_audio_port_pkg::IDX_STAT: rd_nxt[15:0] = stat;
			serial_audio_port_pkg::IDX_RXD: rd_nxt = rx_mem[rx_rp_r];
			default: rd_nxt = '0; // Write-only data port and holes read zero
		endcase
	end

	// APB answer: registered, so every access has exactly one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= rd_nxt;
				pslverr <= (idx == serial_audio_port_pkg::IDX_NONE);
			end
		end
	end

	// Transmit and receive stages; a write or store when full is dropped
	always_ff @(posedge pclk) begin
		if (tx_push) begin
			tx_mem[tx_wp_r] <= pwdata;
		end
		if (rx_push) begin
			rx_mem[rx_wp_r] <= rx_word;
		end
	end

	// Pointers and levels of both FIFOs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			tx_cnt_r <= '0;
			rx_cnt_r <= '0;
		end else begin
			tx_wp_r <= tx_wp_r + serial_audio_port_pkg::ptr_t'(tx_push);
			tx_rp_r <= tx_rp_r + serial_audio_port_pkg::ptr_t'(tx_pop);
			rx_wp_r <= rx_wp_r + serial_audio_port_pkg::ptr_t'(rx_push);
			rx_rp_r <= rx_rp_r + serial_audio_port_pkg::ptr_t'(rx_pop);
			tx_cnt_r <= tx_cnt_r + serial_audio_port_pkg::level_t'(tx_push) - serial_audio_port_pkg::level_t'(tx_pop);
			rx_cnt_r <= rx_cnt_r + serial_audio_port_pkg::level_t'(rx_push) - serial_audio_port_pkg::level_t'(rx_pop);
		end
	end

	// Channel data to the framer; on underflow the old word is kept and resent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_left_half <= '0;
			tx_right_half <= '0;
		end else if (tx_pop) begin
			tx_left_half <= tx_mem[tx_rp_r][`SAP_F_LEFT];
			if (tsa_r[`SAP_B_LREPT] && tsa_r[`SAP_B_RENA]) begin
				tx_right_half <= tx_mem[tx_rp_r][`SAP_F_LEFT];
			end else begin
				tx_right_half <= tx_mem[tx_rp_r][`SAP_F_RIGHT];
			end
		end
	end

	// Slot placement and channel gating; a slot error silences both channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_left_send <= 1'b0;
			tx_right_send <= 1'b0;
			tx_left_slot_num <= '0;
			tx_right_slot_num <= '0;
		end else begin
			tx_left_send <= tsa_r[`SAP_B_LENA] & ~err_r[`SAP_B_SAERR];
			tx_right_send <= tsa_r[`SAP_B_RENA] & ~err_r[`SAP_B_SAERR];
			tx_left_slot_num <= tsa_r[`SAP_F_LSLT];
			tx_right_slot_num <= tsa_r[`SAP_F_RSLT];
		end
	end

	// Master clock events: every pclk, or each rising edge of the pin
	assign mtick = csr_r[`SAP_B_MCSRC] | (external_master_clock_pin & ~ext_d_r);
	assign div_sel = div_total(csr_r[`SAP_F_PRES], csr_r[`SAP_F_ODIV]);
	assign direct = csr_r[`SAP_B_MCDIR] | (div_sel == `SAP_DIV_ONE);

	// Baud counter; high for the first half of each period.
	// Limitation: a direct clock from pclk can only toggle, giving pclk/2.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_d_r <= 1'b0;
			bcnt_r <= '0;
			serial_clock <= 1'b0;
		end else begin
			ext_d_r <= external_master_clock_pin;
			if (direct) begin
				bcnt_r <= '0;
				if (csr_r[`SAP_B_MCSRC]) begin
					serial_clock <= ~serial_clock;
				end else begin
					serial_clock <= external_master_clock_pin;
				end
			end else if (mtick) begin
				if (bcnt_r >= div_sel - `SAP_DIV_ONE) begin
					bcnt_r <= '0;
					serial_clock <= 1'b1;
				end else begin
					bcnt_r <= bcnt_r + `SAP_DIV_ONE;
					if (bcnt_r + `SAP_DIV_ONE == (div_sel >> 1)) begin
						serial_clock <= 1'b0;
					end
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_tx_full_write;
		wr && idx == serial_audio_port_pkg::IDX_TXD && tx_full;
	endsequence
	sequence s_ovf_clear;
		wr && idx == serial_audio_port_pkg::IDX_STAT && pwdata[`SAP_B_TFOVF] && !err_set[`SAP_B_TFOVF];
	endsequence

	a_irq_cause: assert property ((|(ier_r & `SAP_IER_EVT & stat & ~route)) |=> port_irq)
		else $error("interrupt missing for enabled event");
	a_irq_quiet: assert property (ier_r == '0 |=> !port_irq)
		else $error("interrupt with nothing enabled");
	a_tx_route: assert property (!ier_r[`SAP_B_TXDMA] |=> !tx_dma_req)
		else $error("transmit DMA request while CPU selected");
	a_rx_route: assert property (rdreq_nxt && ier_r[`SAP_B_RXDMA] |=> rx_dma_req)
		else $error("receive DMA request lost");
	a_ier_reserved: assert property (ier_r[`SAP_F_IER_RSV] == 2'b00 && csr_r[`SAP_B_CSR_RSV] == 1'b0)
		else $error("reserved bits set");
	a_tx_empty_req: assert property (tx_empty && !tx_push_req |=> tdreq_r)
		else $error("empty transmit FIFO without request");
	a_rx_full_req: assert property (rx_full && !rx_pop_req |=> rdreq_r)
		else $error("full receive FIFO without request");
	a_fifo_depth: assert property (tx_cnt_r <= `SAP_DEPTH && rx_cnt_r <= `SAP_DEPTH)
		else $error("FIFO level beyond sixteen");
	a_tx_overflow: assert property (s_tx_full_write |=> $stable(tx_wp_r) && err_r[`SAP_B_TFOVF])
		else $error("write to full transmit FIFO not flagged");
	a_dma_clear: assert property (tx_push_req && ier_r[`SAP_B_TXDMA] |=> !tdreq_r)
		else $error("DMA access did not clear request");
	a_err_w1c: assert property (s_ovf_clear |=> !err_r[`SAP_B_TFOVF])
		else $error("overflow flag not cleared by one");
	a_repeat_left: assert property (tx_pop && tsa_r[`SAP_B_LREPT] && tsa_r[`SAP_B_RENA]
		|=> tx_right_half == tx_left_half)
		else $error("right slot does not repeat left data");
	a_div_two: assert property ((csr_r == `SAP_CSR_DIV2) [*3] |-> serial_clock != $past(serial_clock))
		else $error("divide by two not toggling");

endmodule // serial_audio_port_control

// *** inc/serial_audio_port_map.svh ***
// Register offsets, field positions, masks and reset values of the serial audio port control block.
// Assumes a 32-bit APB slave with a 12-bit byte address; every register but the 32-bit data ports sits in the low 16 bits of a word.
// What this block does
// - Interrupt when enabled bit meets set status
// - Transmit request goes to DMA or CPU
// - Receive request goes to DMA or CPU
// - One enable bit per event, 7:6 reserved
// - Transmit watermark sets request on empty stages
// - Receive watermark sets request on valid stages
// - Both FIFOs always have sixteen stages
// - Transmit usable area counts free words
// - Receive usable area counts stored words
// - Source bit picks peripheral or pin clock
// - Bypass bit uses master clock directly; from the peripheral clock the code only toggles, giving pclk/2
// - Prescaler divides by one to thirty-two
// - Output divider divides by 2 to 32, or 1
// - Total division is product, at most 1024
// - Slot fields place channels in slots 0-14
// - Left repeat resends left data in right slot
// - Reserved bits read zero
// - One DMA access clears transfer request
// - Error flags clear on writing one
`ifndef SERIAL_AUDIO_PORT_MAP_SVH
`define SERIAL_AUDIO_PORT_MAP_SVH

// Byte addresses on the bus
`define SAP_ADDR_IER 12'h000
`define SAP_ADDR_FCR 12'h004
`define SAP_ADDR_CSR 12'h008
`define SAP_ADDR_TSA 12'h00c
`define SAP_ADDR_STAT 12'h010
`define SAP_ADDR_TXD 12'h014
`define SAP_ADDR_RXD 12'h018

// Writable bits and reset values
`define SAP_IER_WMASK 16'hff3f
`define SAP_IER_EVT 16'h773f
`define SAP_CSR_WMASK 16'hdf07
`define SAP_TSA_WMASK 16'h8fcf
`define SAP_CSR_RST 16'hc000
`define SAP_CSR_DIV2 16'h8000
`define SAP_ERR_W 6

// Bit positions
`define SAP_B_TXDMA 15
`define SAP_B_RXDMA 11
`define SAP_B_TDREQ 12
`define SAP_B_RDREQ 8
`define SAP_B_TXRDY 14
`define SAP_B_TXEMP 13
`define SAP_B_RXRDY 10
`define SAP_B_RXFUL 9
`define SAP_B_MCSRC 15
`define SAP_B_MCDIR 14
`define SAP_B_CSR_RSV 13
`define SAP_B_LENA 15
`define SAP_B_RENA 7
`define SAP_B_LREPT 6
`define SAP_B_SAERR 5
`define SAP_B_FSERR 4
`define SAP_B_TFOVF 3
`define SAP_B_TFUDF 2
`define SAP_B_RFUDF 1
`define SAP_B_RFOVF 0

// Fields
`define SAP_F_TXWM 15:13
`define SAP_F_RXWM 7:5
`define SAP_F_PRES 12:8
`define SAP_F_ODIV 2:0
`define SAP_F_LSLT 11:8
`define SAP_F_RSLT 3:0
`define SAP_F_IER_RSV 7:6
`define SAP_F_ERR 5:0
`define SAP_F_LEFT 31:16
`define SAP_F_RIGHT 15:0

// FIFO depth and watermark levels
`define SAP_DEPTH 5'h10
`define SAP_LVL_1 5'h01
`define SAP_LVL_4 5'h04
`define SAP_LVL_8 5'h08
`define SAP_LVL_12 5'h0c
`define SAP_DIV_ONE 11'h001

`endif

// *** inc/serial_audio_port_pkg.sv ***
// Types shared by the serial audio port control block.
// Assumes the map header supplies all numbers.
package serial_audio_port_pkg;
	typedef logic [15:0] reg16_t; // One 16-bit register
	typedef logic [4:0] level_t; // FIFO fill level, 0 to 16
	typedef logic [3:0] ptr_t; // FIFO stage pointer
	typedef logic [10:0] div_t; // Total baud division, 1 to 1024
	typedef enum {IDX_IER, IDX_FCR, IDX_CSR, IDX_TSA, IDX_STAT, IDX_TXD, IDX_RXD, IDX_NONE} reg_idx_t;
endpackage
